// *** dmrb_cfg.svh ***
// Constants of the mode-register bank: addresses, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DMRB_CFG_SVH
`define DMRB_CFG_SVH

// ************************************************
// Register addresses
// ************************************************
`define DMRB_ADDR_INFO 6'h00
`define DMRB_ADDR_FEAT 6'h01
`define DMRB_ADDR_PAT2 6'h28

// ************************************************
// Field positions and reset values
// ************************************************
`define DMRB_INFO_REF_BIT 0
`define DMRB_INFO_LAT_BIT 1
`define DMRB_INFO_RANK_BIT 7
`define DMRB_FEAT_RESET 8'h04
`define DMRB_BURST_16 2'h0
`define DMRB_BURST_32 2'h1
`define DMRB_BURST_OTF 2'h2
`define DMRB_ST_NONE 2'h0
`define DMRB_ST_GROUND 2'h1
`define DMRB_ST_SUPPLY 2'h2
`define DMRB_ST_PASS 2'h3

// ************************************************
// Timing
// ************************************************
`define DMRB_CLK_MHZ 20
`define DMRB_ZQLAT_NS 30
`define DMRB_ZQLAT_CYC ((`DMRB_ZQLAT_NS * `DMRB_CLK_MHZ + 999) / 1000)

`endif

// *** dmrb_pkg.sv ***
// Types shared by the mode-register bank.
// Assumes dmrb_cfg.svh sits in the include path.
`default_nettype none
`include "dmrb_cfg.svh"

package dmrb_pkg;

    // One copy of the feature register fields.
    typedef struct packed {
        logic rdPostLong;
        logic [2:0] wrRecovery;
        logic rdPreToggle;
        logic wrPre2nck;
        logic [1:0] burstMode;
    } dmrb_feature_t;

    // Mode register command as sampled on the link clock.
    typedef struct packed {
        logic valid;
        logic write;
        logic [5:0] addr;
        logic [7:0] data;
    } dmrb_mr_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STARTED,
        ST_LATCH,
        ST_DONE
    } dmrb_zq_state_t;

endpackage

`default_nettype wire

// *** dmrb_mode_regs.sv ***
// Mode-register bank: device information, feature register with two
// set points, and the resistor self-test sequencer.
// Assumes commands arrive on linkClk and the pin straps are asynchronous.
`default_nettype none
`include "dmrb_cfg.svh"

module dmrb_mode_regs
    import dmrb_pkg::*;
#(
    parameter logic REFRESH_MODIFIED_ONLY = 1'b0,
    parameter logic BYTE_MODE_LATENCY = 1'b0,
    parameter int ZQLAT_CYC = `DMRB_ZQLAT_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic linkClk,
    input wire dmrb_mr_cmd_t mrCmd,
    input wire logic zqStartCmd,
    input wire logic zqLatchCmd,
    input wire logic accessValid,
    input wire logic accessBurstSel,
    input wire logic writeAutoPreDone,
    input wire logic setpointWriteSelect,
    input wire logic setpointOperateSelect,
    input wire logic caTermEnable,
    input wire logic [2:0] caTermValue,
    input wire logic zqPinGround,
    input wire logic zqPinSupply,
    output logic rdValid,
    output logic [7:0] rdData,
    output logic rdStrobeToggle,
    output logic burstLength32,
    output logic writePreamble2nck,
    output logic readPreambleToggle,
    output logic readPostambleLong,
    output logic prechargeStart,
    output logic [7:0] patternSecond,
    output logic factoryTrimActive
);

    // ************************************************
    // Functions
    // ************************************************
    function automatic logic [5:0] wr_cycles(input logic [2:0] code);
        logic [5:0] n;
        n = 6'h06;
        case (code)
            3'h0: n = 6'h06;
            3'h1: n = 6'h0a;
            3'h2: n = 6'h10;
            3'h3: n = 6'h14;
            3'h4: n = 6'h18;
            3'h5: n = 6'h1e;
            3'h6: n = 6'h22;
            3'h7: n = 6'h28;
            default: n = 6'h06;
        endcase
        return n;
    endfunction

    function automatic logic st_error(input logic [1:0] code);
        return (code == `DMRB_ST_GROUND) || (code == `DMRB_ST_SUPPLY);
    endfunction

    // ************************************************
    // Link-side reset
    // ************************************************
    // The core reset reaches the link domain through two flops.
    logic linkRst1_q;
    logic linkRst_q;

    always_ff @(posedge linkClk) begin
        linkRst1_q <= srst;
        linkRst_q <= linkRst1_q;
    end

    // ************************************************
    // Feature register copies
    // ************************************************
    dmrb_feature_t featCopy_q [2];
    dmrb_feature_t featActive;
    logic featWrite;
    assign featWrite = mrCmd.valid && mrCmd.write && mrCmd.addr == `DMRB_ADDR_FEAT;
    assign featActive = featCopy_q[setpointOperateSelect];

    generate
        for (genvar i = 0; i < 2; i++) begin : g_copy
            always_ff @(posedge linkClk) begin
                if (linkRst_q) begin
                    featCopy_q[i] <= dmrb_feature_t'(`DMRB_FEAT_RESET);
                end else if (featWrite && setpointWriteSelect == 1'(i)) begin
                    featCopy_q[i] <= dmrb_feature_t'(mrCmd.data);
                end
            end
        end
    endgenerate

    // Writes to the read-only and reserved addresses fall through untouched.
    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            patternSecond <= 8'h00;
        end else if (mrCmd.valid && mrCmd.write && mrCmd.addr == `DMRB_ADDR_PAT2) begin
            patternSecond <= mrCmd.data;
        end
    end

    // ************************************************
    // Self-test result crossing into the link domain
    // ************************************************
    logic stValid_q;
    logic [1:0] stCode_q;
    logic [2:0] stSync1_q;
    logic [2:0] stSync2_q;

    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            stSync1_q <= 3'h0;
            stSync2_q <= 3'h0;
        end else begin
            stSync1_q <= {stValid_q, stCode_q};
            stSync2_q <= stSync1_q;
        end
    end

    // ************************************************
    // Mode register read
    // ************************************************
    logic [7:0] infoValue;
    logic rankFlag;

    assign rankFlag = caTermEnable && caTermValue != 3'h0;

    always_comb begin
        infoValue = 8'h00;
        infoValue[`DMRB_INFO_REF_BIT] = REFRESH_MODIFIED_ONLY;
        infoValue[`DMRB_INFO_LAT_BIT] = BYTE_MODE_LATENCY;
        infoValue[4:3] = stSync2_q[2] ? stSync2_q[1:0] : `DMRB_ST_NONE;
        infoValue[`DMRB_INFO_RANK_BIT] = rankFlag;
    end

    // Every read answers and toggles the strobe; only address zero has data.
    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            rdValid <= 1'b0;
            rdStrobeToggle <= 1'b0;
            rdData <= 8'h00;
        end else begin
            rdValid <= mrCmd.valid && !mrCmd.write;
            rdStrobeToggle <= mrCmd.valid && !mrCmd.write;
            if (mrCmd.valid && !mrCmd.write) begin
                rdData <= (mrCmd.addr == `DMRB_ADDR_INFO) ? infoValue : 8'h00;
            end
        end
    end

    // ************************************************
    // Operating outputs
    // ************************************************
    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            writePreamble2nck <= 1'b1;
            readPreambleToggle <= 1'b0;
            readPostambleLong <= 1'b0;
        end else begin
            writePreamble2nck <= featActive.wrPre2nck;
            readPreambleToggle <= featActive.rdPreToggle;
            readPostambleLong <= featActive.rdPostLong;
        end
    end

    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            burstLength32 <= 1'b0;
        end else if (accessValid) begin
            case (featActive.burstMode)
                `DMRB_BURST_32: burstLength32 <= 1'b1;
                `DMRB_BURST_OTF: burstLength32 <= accessBurstSel;
                default: burstLength32 <= 1'b0;
            endcase
        end
    end

    // ************************************************
    // Write recovery before auto precharge
    // ************************************************
    // Loaded one short so the registered pulse lands the programmed count of edges later.
    logic [5:0] wrCnt_q;

    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            wrCnt_q <= 6'h00;
            prechargeStart <= 1'b0;
        end else begin
            prechargeStart <= wrCnt_q == 6'h01;
            if (writeAutoPreDone) begin
                wrCnt_q <= wr_cycles(featActive.wrRecovery) - 6'h01;
            end else if (wrCnt_q != 6'h00) begin
                wrCnt_q <= wrCnt_q - 6'h01;
            end
        end
    end

    // ************************************************
    // Calibration command crossing into the core domain
    // ************************************************
    logic startTgl_q;
    logic latchTgl_q;

    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            startTgl_q <= 1'b0;
            latchTgl_q <= 1'b0;
        end else begin
            startTgl_q <= startTgl_q ^ zqStartCmd;
            latchTgl_q <= latchTgl_q ^ zqLatchCmd;
        end
    end

    logic [2:0] startSync_q;
    logic [2:0] latchSync_q;
    logic [1:0] pinSync1_q;
    logic [1:0] pinSync2_q;
    logic startSeen;
    logic latchSeen;

    always_ff @(posedge clk) begin
        if (srst) begin
            startSync_q <= 3'h0;
            latchSync_q <= 3'h0;
            pinSync1_q <= 2'h0;
            pinSync2_q <= 2'h0;
        end else begin
            startSync_q <= {startSync_q[1:0], startTgl_q};
            latchSync_q <= {latchSync_q[1:0], latchTgl_q};
            pinSync1_q <= {zqPinSupply, zqPinGround};
            pinSync2_q <= pinSync1_q;
        end
    end

    assign startSeen = startSync_q[2] ^ startSync_q[1];
    assign latchSeen = latchSync_q[2] ^ latchSync_q[1];

    // ************************************************
    // Self-test sequencer
    // ************************************************
    // The code is captured before valid rises so the link side sees it settled.
    dmrb_zq_state_t zqState_q;
    logic [7:0] latCnt_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            zqState_q <= ST_IDLE;
            latCnt_q <= 8'h00;
            stCode_q <= `DMRB_ST_NONE;
            stValid_q <= 1'b0;
            factoryTrimActive <= 1'b0;
        end else begin
            case (zqState_q)
                ST_IDLE: begin
                    if (startSeen) begin
                        zqState_q <= ST_STARTED;
                    end
                end
                ST_STARTED: begin
                    if (latchSeen) begin
                        zqState_q <= ST_LATCH;
                        latCnt_q <= 8'(ZQLAT_CYC);
                        if (pinSync2_q[0]) begin
                            stCode_q <= `DMRB_ST_GROUND;
                        end else if (pinSync2_q[1]) begin
                            stCode_q <= `DMRB_ST_SUPPLY;
                        end else begin
                            stCode_q <= `DMRB_ST_PASS;
                        end
                    end
                end
                ST_LATCH: begin
                    if (latCnt_q <= 8'h01) begin
                        zqState_q <= ST_DONE;
                        stValid_q <= 1'b1;
                        factoryTrimActive <= st_error(stCode_q);
                    end else begin
                        latCnt_q <= latCnt_q - 8'h01;
                    end
                end
                ST_DONE: begin
                    if (startSeen && !factoryTrimActive) begin
                        zqState_q <= ST_STARTED;
                        stValid_q <= 1'b0;
                    end
                end
                default: zqState_q <= ST_IDLE;
            endcase
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    a_info_rfu_zero: assert property (@(posedge linkClk) disable iff (linkRst_q)
        mrCmd.valid && !mrCmd.write && mrCmd.addr == `DMRB_ADDR_INFO
        |=> rdData[6:5] == 2'h0 && !rdData[2])
        else $error("Reserved info bits read nonzero.");

    a_read_strobe: assert property (@(posedge linkClk) disable iff (linkRst_q)
        mrCmd.valid && !mrCmd.write |=> rdValid && rdStrobeToggle)
        else $error("Read without strobe toggle.");

    a_ro_write_none: assert property (@(posedge linkClk) disable iff (linkRst_q)
        mrCmd.valid && mrCmd.write && mrCmd.addr == `DMRB_ADDR_INFO
        |=> $stable(featCopy_q[0]) && $stable(featCopy_q[1]))
        else $error("Read-only write changed state.");

    a_rank_flag: assert property (@(posedge linkClk) disable iff (linkRst_q)
        mrCmd.valid && !mrCmd.write && mrCmd.addr == `DMRB_ADDR_INFO
        |=> rdData[7] == ($past(caTermEnable) && $past(caTermValue) != 3'h0))
        else $error("CA rank flag wrong.");

    a_setpoint_write: assert property (@(posedge linkClk) disable iff (linkRst_q)
        featWrite |=> featCopy_q[$past(setpointWriteSelect)] == $past(mrCmd.data)
        && $stable(featCopy_q[!$past(setpointWriteSelect)]))
        else $error("Set-point write hit the wrong copy.");

    a_burst_otf: assert property (@(posedge linkClk) disable iff (linkRst_q)
        accessValid && featActive.burstMode == `DMRB_BURST_OTF
        |=> burstLength32 == $past(accessBurstSel))
        else $error("Per-command burst not followed.");

    a_wr_rec_min: assert property (@(posedge linkClk) disable iff (linkRst_q)
        writeAutoPreDone && featActive.wrRecovery == 3'h0 ##1 !writeAutoPreDone[*5]
        |-> ##1 prechargeStart)
        else $error("Precharge not at six cycles.");

    a_wr_rec_max: assert property (@(posedge linkClk) disable iff (linkRst_q)
        writeAutoPreDone && featActive.wrRecovery == 3'h7
        |-> ##1 !prechargeStart[*8])
        else $error("Precharge too early for code seven.");

    a_st_order: assert property (@(posedge clk) disable iff (srst)
        $rose(stValid_q) |-> $past(zqState_q) == ST_LATCH)
        else $error("Self-test valid without latch.");

    a_trim_fallback: assert property (@(posedge clk) disable iff (srst)
        stValid_q && st_error(stCode_q) |-> factoryTrimActive && zqState_q == ST_DONE)
        else $error("Error result without fallback.");

endmodule

`default_nettype wire

// *** dmrb_ctrl_model.sv ***
// Controller model: issues mode register, calibration and access commands.
// Assumes the bench calls its tasks only after reset has been released.
`default_nettype none
`include "dmrb_cfg.svh"

module dmrb_ctrl_model
    import dmrb_pkg::*;
(
    input wire logic linkClk,
    output var dmrb_mr_cmd_t mrCmd,
    output logic zqStartCmd,
    output logic zqLatchCmd,
    output logic accessValid,
    output logic accessBurstSel,
    output logic writeAutoPreDone
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        mrCmd = '0;
        {zqStartCmd, zqLatchCmd, accessValid, accessBurstSel, writeAutoPreDone} = 5'h00;
    end

    // ************************************************
    // Mode register commands
    // ************************************************
    // Released lines show the inverse so stale values are never trusted.
    task automatic issue(input logic wr, input logic [5:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (!(a >= 6'h29 || (wr && a >= 6'h1a && a <= 6'h1f))) begin
            if (wr && a == `DMRB_ADDR_FEAT) begin
                v[2] = 1'b1;
                if (v[1:0] == 2'h3) begin
                    v[1:0] = `DMRB_BURST_16;
                end
            end
            @(posedge linkClk);
            #2;
            mrCmd <= '{valid: 1'b1, write: wr, addr: a, data: v};
            @(posedge linkClk);
            #2;
            mrCmd <= '{valid: 1'b0, write: ~wr, addr: ~a, data: ~v};
        end
    endtask

    // ************************************************
    // Single-cycle pulses
    // ************************************************
    task automatic pulse(input logic [1:0] kind, input logic sel);
        @(posedge linkClk);
        #2;
        case (kind)
            2'h0: zqStartCmd <= 1'b1;
            2'h1: zqLatchCmd <= 1'b1;
            2'h2: accessValid <= 1'b1;
            default: writeAutoPreDone <= 1'b1;
        endcase
        accessBurstSel <= sel;
        @(posedge linkClk);
        #2;
        {zqStartCmd, zqLatchCmd, accessValid, writeAutoPreDone} <= 4'h0;
        accessBurstSel <= ~sel;
    endtask
endmodule

`default_nettype wire

// *** tb_top.sv ***
// Testbench of the mode-register bank: one task per scenario, then verdict.
// Assumes the controller model drives the command side on linkClk.
`default_nettype none

module tb_top
    import dmrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, srst, linkClk, accessValid, accessBurstSel, writeAutoPreDone, zqStartCmd, zqLatchCmd;
    logic setpointWriteSelect, setpointOperateSelect, caTermEnable, zqPinGround, zqPinSupply;
    logic [2:0] caTermValue;
    dmrb_mr_cmd_t mrCmd;
    logic rdValid, rdStrobeToggle, burstLength32, writePreamble2nck, readPreambleToggle;
    logic readPostambleLong, prechargeStart, factoryTrimActive;
    logic [7:0] rdData, patternSecond, dataSeen;
    logic rdSeen, stbSeen, pcSeen;
    int errCount = 0;
    int samplesChecked = 0;

    dmrb_ctrl_model ctrl (.linkClk(linkClk), .mrCmd(mrCmd), .zqStartCmd(zqStartCmd),
        .zqLatchCmd(zqLatchCmd), .accessValid(accessValid), .accessBurstSel(accessBurstSel),
        .writeAutoPreDone(writeAutoPreDone));

    dmrb_mode_regs #(.REFRESH_MODIFIED_ONLY(1'b1), .BYTE_MODE_LATENCY(1'b0)) DUT (.clk(clk),
        .srst(srst), .linkClk(linkClk), .mrCmd(mrCmd), .zqStartCmd(zqStartCmd), .zqLatchCmd(zqLatchCmd),
        .accessValid(accessValid), .accessBurstSel(accessBurstSel), .writeAutoPreDone(writeAutoPreDone),
        .setpointWriteSelect(setpointWriteSelect), .setpointOperateSelect(setpointOperateSelect),
        .caTermEnable(caTermEnable), .caTermValue(caTermValue), .zqPinGround(zqPinGround),
        .zqPinSupply(zqPinSupply), .rdValid(rdValid), .rdData(rdData), .rdStrobeToggle(rdStrobeToggle),
        .burstLength32(burstLength32), .writePreamble2nck(writePreamble2nck),
        .readPreambleToggle(readPreambleToggle), .readPostambleLong(readPostambleLong),
        .prechargeStart(prechargeStart), .patternSecond(patternSecond), .factoryTrimActive(factoryTrimActive));

    // ************************************************
    // Clocks and edge samplers
    // ************************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        linkClk = 1'b0;
        #7;
        forever #16 linkClk = ~linkClk;
    end
    // Pulses are judged by the value seen at the edge, free of races.
    always @(posedge linkClk) begin
        rdSeen <= rdValid;
        stbSeen <= rdStrobeToggle;
        dataSeen <= rdData;
        pcSeen <= prechargeStart;
    end

    // ************************************************
    // Shared tasks
    // ************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrapUp();
        $display("checks=%0d mismatches=%0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic waitLink(input int n);
        repeat (n) @(posedge linkClk);
        #1;
    endtask

    task automatic mrRead(input logic [5:0] a, output logic [7:0] d, output logic s);
        d = 8'hxx;
        s = 1'b0;
        ctrl.issue(1'b0, a, 8'h00);
        for (int k = 0; k < 3; k++) begin
            waitLink(1);
            if (rdSeen === 1'b1) begin
                d = dataSeen;
                s = stbSeen;
                break;
            end
        end
    endtask

    task automatic doReset();
        @(posedge clk);
        #2;
        srst = 1'b1;
        repeat (16) @(posedge clk);
        #2;
        srst = 1'b0;
        waitLink(6);
    endtask

    task automatic setLevels(input logic wr, input logic op, input logic en, input logic [2:0] val);
        @(posedge linkClk);
        #2;
        {setpointWriteSelect, setpointOperateSelect, caTermEnable, caTermValue} = {wr, op, en, val};
        waitLink(3);
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic tResetValues();
        check({writePreamble2nck, readPreambleToggle, readPostambleLong}, 3'h4);
        check({burstLength32, patternSecond, factoryTrimActive}, 10'h000);
    endtask

    task automatic tInfo();
        logic [7:0] d;
        logic s;
        logic [3:0] en = 4'b1100;
        logic [2:0] val[4] = '{3'h0, 3'h5, 3'h0, 3'h7};
        for (int i = 0; i < 4; i++) begin
            setLevels(1'b0, 1'b0, en[i], val[i]);
            mrRead(6'h00, d, s);
            check(d, {en[i] && val[i] != 3'h0, 7'h01});
            ctrl.issue(1'b1, 6'h00, 8'hff);
            mrRead(6'h00, d, s);
            check(d, {en[i] && val[i] != 3'h0, 7'h01});
        end
        setLevels(1'b0, 1'b0, 1'b0, 3'h0);
    endtask

    task automatic tUnreadable();
        logic [7:0] d;
        logic s;
        logic [5:0] addrs[3] = '{6'h01, 6'h28, 6'h1a};
        foreach (addrs[i]) begin
            mrRead(addrs[i], d, s);
            check({s, d}, 9'h100);
        end
    endtask

    task automatic tSetpoint();
        setLevels(1'b1, 1'b0, 1'b0, 3'h0);
        ctrl.issue(1'b1, 6'h01, 8'hbd);
        waitLink(3);
        check({readPreambleToggle, readPostambleLong, burstLength32}, 3'h0);
        setLevels(1'b1, 1'b1, 1'b0, 3'h0);
        check({readPreambleToggle, readPostambleLong, writePreamble2nck}, 3'h7);
        setLevels(1'b0, 1'b0, 1'b0, 3'h0);
        check({readPreambleToggle, readPostambleLong}, 2'h0);
    endtask

    task automatic tBurst();
        for (int m = 0; m < 3; m++) begin
            for (int sel = 0; sel < 2; sel++) begin
                ctrl.issue(1'b1, 6'h01, {6'h01, m[1:0]});
                ctrl.pulse(2'h2, sel[0]);
                waitLink(3);
                check(burstLength32, m == 1 || (m == 2 && sel == 1));
            end
        end
    endtask

    task automatic tRecovery();
        int write_recovery_cycles[8] = '{6, 10, 16, 20, 24, 30, 34, 40};
        int k;
        for (int c = 0; c < 8; c++) begin
            ctrl.issue(1'b1, 6'h01, {1'b0, c[2:0], 4'h4});
            waitLink(3);
            ctrl.pulse(2'h3, 1'b0);
            for (k = 1; k < 60; k++) begin
                waitLink(1);
                if (pcSeen === 1'b1) begin
                    break;
                end
            end
            check(k, write_recovery_cycles[c]);
        end
    endtask

    task automatic tPattern();
        ctrl.issue(1'b1, 6'h28, 8'h5a);
        waitLink(3);
        check(patternSecond, 8'h5a);
    endtask

    task automatic tSelfTest(input logic gnd, input logic sup, input logic [1:0] exp);
        logic [7:0] d;
        logic s;
        @(posedge clk);
        #2;
        {zqPinGround, zqPinSupply} = {gnd, sup};
        repeat (4) @(posedge clk);
        ctrl.pulse(2'h0, 1'b0);
        waitLink(4);
        ctrl.pulse(2'h1, 1'b0);
        for (int k = 0; k < 40; k++) begin
            mrRead(6'h00, d, s);
            if (d[4:3] !== 2'h0) begin
                break;
            end
        end
        check(d[4:3], exp);
        check(factoryTrimActive, exp != 2'h3);
        @(posedge clk);
        #2;
        {zqPinGround, zqPinSupply} = 2'h0;
        ctrl.pulse(2'h0, 1'b0);
        waitLink(4);
        ctrl.pulse(2'h1, 1'b0);
        waitLink(20);
        mrRead(6'h00, d, s);
        check(d[4:3], exp);
        doReset();
        mrRead(6'h00, d, s);
        check(d[4:3], 2'h0);
    endtask

    // ************************************************
    // Main sequence and watchdog
    // ************************************************
    initial begin
        srst = 1'b1;
        {setpointWriteSelect, setpointOperateSelect, caTermEnable, caTermValue} = 6'h00;
        {zqPinGround, zqPinSupply} = 2'h0;
        repeat (16) @(posedge clk);
        #2;
        srst = 1'b0;
        waitLink(6);
        tResetValues();
        tInfo();
        tUnreadable();
        tSetpoint();
        tBurst();
        tRecovery();
        tPattern();
        tSelfTest(1'b0, 1'b0, 2'h3);
        tSelfTest(1'b1, 1'b0, 2'h1);
        tSelfTest(1'b0, 1'b1, 2'h2);
        wrapUp();
    end

    // The whole run needs well under 200 us; this margin cuts a hang.
    initial begin
        #1_000_000;
        errCount++;
        wrapUp();
    end
endmodule

`default_nettype wire
